// ===== pkg/csi_rx_pkg.sv
package csi_rx_pkg;
	localparam int NLANE = 4;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MAP  = 8'h04;
	localparam logic [7:0] OFF_VRMP = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [7:0] OFF_MASK = 8'h10;
	localparam logic [7:0] OFF_HDR  = 8'h14;
	localparam int C_PIX = 2;
	localparam int C_CRC = 3;
	localparam int V_EN  = 14;
	localparam logic [4:0]  CTRL_RST = 5'h0B;
	localparam logic [11:0] MAP_RST  = 12'h0E4;
	localparam logic [14:0] VRMP_RST = 15'h0000;
	localparam logic [3:0]  STAT_RST = 4'h0;
	localparam logic [3:0]  MASK_RST = 4'h0;
	localparam int S_CRC = 0;
	localparam int S_PKT = 1;
	localparam int S_DSK = 2;
	localparam int S_FS  = 3;
	localparam logic [7:0]  SYNC_BYTE   = 8'hB8;
	localparam logic [7:0]  DESKEW_BYTE = 8'hFF;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [5:0]  DT_LONG_MIN = 6'h10;
	localparam logic [5:0]  DT_FS = 6'h00;
	typedef enum logic [1:0] {PS_HDR, PS_PAY, PS_CRC} parse_e;
endpackage

// ===== rtl/csi_rx.sv
// Contract
// - One to four data lanes selectable
// - Any logical lane maps any physical lane
// - Per-lane polarity inversion
// - Lane rate up to 2.5Gbps
// - Accept continuous and burst lane clock
// - Decode 16 virtual channels with extension
// - Pixel mode remaps VC/DT, tunneling passes
// - Deskew on transmitter patterns
// - Line check can be disabled
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module csi_rx
	import csi_rx_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Link pins
	input  wire logic        lane_clk,
	input  wire logic        lane_hs,
	input  wire logic [3:0]  lane_dat,
	// Byte stream and headers
	output logic             pix_valid,
	output logic      [7:0]  pix_byte,
	output logic             hdr_valid,
	output logic      [3:0]  hdr_vc,
	output logic      [5:0]  hdr_dt,
	output logic      [15:0] hdr_wc,
	// Interrupt
	output logic             irq
);
	import csi_rx_pkg::*;

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int k = 0; k < 8; k++) begin
			r = (r[0] ^ b[k]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	logic [5:0]  sy1_q, sy2_q;
	logic        clk_prev_q;
	logic        hs, ledge;
	logic [4:0]  ctrl_q, ctrl_d;
	logic [11:0] map_q, map_d;
	logic [14:0] vrmp_q, vrmp_d;
	logic [3:0]  sts_q, sts_d, msk_q, msk_d, ev;
	logic [31:0] rdat_q, rdat_d;
	logic        irq_q, irq_d;
	logic [2:0]  nl;
	logic [3:0]  act, dhit, have, lkv, hvl;
	logic [31:0] bytes_w;
	logic        dsk_any, gather;
	logic [31:0] hold_q, hold_d;
	logic        emit_q, emit_d;
	logic [1:0]  idx_q, idx_d;
	logic [7:0]  bb;
	parse_e      ps_q, ps_d;
	logic [15:0] pc_q, pc_d, wc_q, wc_d, crc_q, crc_d;
	logic [23:0] hb_q, hb_d;
	logic [7:0]  ck_q, ck_d, pb_q, pb_d;
	logic        pv_q, pv_d, hdv_q, hdv_d;
	logic [3:0]  hvc_q, hvc_d, rvc;
	logic [5:0]  hdt_q, hdt_d, rdt;
	logic [15:0] hwc_q, hwc_d;
	logic        crc_ev, pkt_ev, fs_ev;

	// Clock, burst flag and data all take the same two stages, so they stay aligned.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q      <= 6'h00;
			sy2_q      <= 6'h00;
			clk_prev_q <= 1'b0;
		end else begin
			sy1_q      <= {lane_hs, lane_clk, lane_dat};
			sy2_q      <= sy1_q;
			clk_prev_q <= sy2_q[4];
		end
	end

	// The lane clock is oversampled; the top lane rate is bounded by the sampling rate.
	assign hs    = sy2_q[5];
	assign ledge = sy2_q[4] & ~clk_prev_q & hs;
	assign nl    = {1'b0, ctrl_q[1:0]} + 3'd1;
	assign dsk_any = |dhit;

	genvar gi;
	generate
		for (gi = 0; gi < NLANE; gi++) begin : g_lane
			logic [1:0] ph;
			logic       bt;
			logic [7:0] sh_q, sh_d, by_q, by_d;
			logic [2:0] bc_q, bc_d;
			logic       lk_q, lk_d, hv_q, hv_d;
			assign ph = map_q[2*gi +: 2];
			assign bt = sy2_q[ph] ^ map_q[8 + ph];
			assign act[gi] = (gi < nl);
			assign dhit[gi] = ledge & ~lk_q & act[gi] & ({bt, sh_q[7:1]} == DESKEW_BYTE);
			always_comb begin
				sh_d = sh_q;
				lk_d = lk_q;
				bc_d = bc_q;
				by_d = by_q;
				hv_d = hv_q & ~gather;
				// Alignment is dropped at every burst end, so a stopped clock is harmless.
				if (!hs || dsk_any || !act[gi]) begin
					sh_d = 8'h00;
					lk_d = 1'b0;
					hv_d = 1'b0;
				end else if (ledge) begin
					sh_d = {bt, sh_q[7:1]};
					if (!lk_q) begin
						if (sh_d == SYNC_BYTE) begin
							lk_d = 1'b1;
							bc_d = 3'd0;
						end
					end else begin
						bc_d = bc_q + 3'd1;
						if (bc_q == 3'd7) begin
							by_d = sh_d;
							hv_d = 1'b1;
						end
					end
				end
			end
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					sh_q <= 8'h00;
					by_q <= 8'h00;
					bc_q <= 3'd0;
					lk_q <= 1'b0;
					hv_q <= 1'b0;
				end else begin
					sh_q <= sh_d;
					by_q <= by_d;
					bc_q <= bc_d;
					lk_q <= lk_d;
					hv_q <= hv_d;
				end
			end
			assign have[gi] = hv_q | ~act[gi];
			assign hvl[gi]  = hv_q;
			assign lkv[gi]  = lk_q;
			assign bytes_w[8*gi +: 8] = by_q;
		end
	endgenerate

	// Waiting for every active lane absorbs sub-byte skew between lanes.
	assign gather = (&have) & hvl[0] & ~emit_q;
	assign bb = hold_q[8*idx_q +: 8];

	always_comb begin
		hold_d = hold_q;
		emit_d = emit_q;
		idx_d  = idx_q;
		if (gather) begin
			hold_d = bytes_w;
			emit_d = 1'b1;
			idx_d  = 2'd0;
		end else if (emit_q) begin
			idx_d = idx_q + 2'd1;
			if ({1'b0, idx_q} == nl - 3'd1) begin
				emit_d = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 32'h0000_0000;
			emit_q <= 1'b0;
			idx_q  <= 2'd0;
		end else begin
			hold_q <= hold_d;
			emit_q <= emit_d;
			idx_q  <= idx_d;
		end
	end

	assign rvc = {bb[7:6], hb_q[7:6]};
	assign rdt = hb_q[5:0];

	always_comb begin
		ps_d   = ps_q;
		pc_d   = pc_q;
		wc_d   = wc_q;
		crc_d  = crc_q;
		hb_d   = hb_q;
		ck_d   = ck_q;
		pv_d   = 1'b0;
		pb_d   = pb_q;
		hdv_d  = 1'b0;
		hvc_d  = hvc_q;
		hdt_d  = hdt_q;
		hwc_d  = hwc_q;
		crc_ev = 1'b0;
		pkt_ev = 1'b0;
		fs_ev  = 1'b0;
		if (!hs) begin
			ps_d = PS_HDR;
			pc_d = 16'd0;
		end else if (emit_q) begin
			case (ps_q)
				PS_HDR: begin
					pc_d = pc_q + 16'd1;
					if (pc_q < 16'd3) begin
						hb_d = {bb, hb_q[23:8]};
					end else begin
						hdv_d  = 1'b1;
						pkt_ev = 1'b1;
						fs_ev  = (rdt == DT_FS);
						hvc_d  = rvc;
						hdt_d  = rdt;
						hwc_d  = hb_q[23:8];
						pc_d   = 16'd0;
						if (ctrl_q[C_PIX] && vrmp_q[V_EN] && rvc == vrmp_q[3:0]) begin
							hvc_d = vrmp_q[7:4];
							hdt_d = vrmp_q[13:8];
						end
						if (rdt >= DT_LONG_MIN && hb_q[23:8] != 16'd0) begin
							ps_d  = PS_PAY;
							wc_d  = hb_q[23:8];
							crc_d = CRC_INIT;
						end
					end
				end
				PS_PAY: begin
					pv_d  = 1'b1;
					pb_d  = bb;
					crc_d = crc_upd(crc_q, bb);
					pc_d  = pc_q + 16'd1;
					if (pc_q == wc_q - 16'd1) begin
						ps_d = PS_CRC;
						pc_d = 16'd0;
					end
				end
				PS_CRC: begin
					if (pc_q == 16'd0) begin
						ck_d = bb;
						pc_d = 16'd1;
					end else begin
						ps_d   = PS_HDR;
						pc_d   = 16'd0;
						crc_ev = ctrl_q[C_CRC] && ({bb, ck_q} != crc_q);
					end
				end
				default: ps_d = PS_HDR;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_q  <= PS_HDR;
			pc_q  <= 16'd0;
			wc_q  <= 16'd0;
			crc_q <= CRC_INIT;
			hb_q  <= 24'h000000;
			ck_q  <= 8'h00;
			pv_q  <= 1'b0;
			pb_q  <= 8'h00;
			hdv_q <= 1'b0;
			hvc_q <= 4'h0;
			hdt_q <= 6'h00;
			hwc_q <= 16'h0000;
		end else begin
			ps_q  <= ps_d;
			pc_q  <= pc_d;
			wc_q  <= wc_d;
			crc_q <= crc_d;
			hb_q  <= hb_d;
			ck_q  <= ck_d;
			pv_q  <= pv_d;
			pb_q  <= pb_d;
			hdv_q <= hdv_d;
			hvc_q <= hvc_d;
			hdt_q <= hdt_d;
			hwc_q <= hwc_d;
		end
	end

	always_comb begin
		ctrl_d = ctrl_q;
		map_d  = map_q;
		vrmp_d = vrmp_q;
		msk_d  = msk_q;
		ev     = 4'h0;
		ev[S_CRC] = crc_ev;
		ev[S_PKT] = pkt_ev;
		ev[S_DSK] = dsk_any;
		ev[S_FS]  = fs_ev;
		if (reg_wr) begin
			case (reg_addr)
				OFF_CTRL: ctrl_d = reg_wdata[4:0];
				OFF_MAP:  map_d  = reg_wdata[11:0];
				OFF_VRMP: vrmp_d = reg_wdata[14:0];
				OFF_MASK: msk_d  = reg_wdata[3:0];
				default:  ctrl_d = ctrl_q;
			endcase
		end
		// A new event in the clearing read's cycle survives the clear.
		sts_d = (reg_rd && reg_addr == OFF_STAT) ? ev : (sts_q | ev);
		case (reg_addr)
			OFF_CTRL: rdat_d = {27'h0, ctrl_q};
			OFF_MAP:  rdat_d = {20'h0, map_q};
			OFF_VRMP: rdat_d = {17'h0, vrmp_q};
			OFF_STAT: rdat_d = {28'h0, sts_q};
			OFF_MASK: rdat_d = {28'h0, msk_q};
			OFF_HDR:  rdat_d = {6'h0, hwc_q, hdt_q, hvc_q};
			default:  rdat_d = 32'h0000_0000;
		endcase
		if (!reg_rd) begin
			rdat_d = 32'h0000_0000;
		end
		irq_d = |(sts_d & msk_d);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RST;
			map_q  <= MAP_RST;
			vrmp_q <= VRMP_RST;
			sts_q  <= STAT_RST;
			msk_q  <= MASK_RST;
			rdat_q <= 32'h0000_0000;
			irq_q  <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			map_q  <= map_d;
			vrmp_q <= vrmp_d;
			sts_q  <= sts_d;
			msk_q  <= msk_d;
			rdat_q <= rdat_d;
			irq_q  <= irq_d;
		end
	end

	assign reg_rdata = rdat_q;
	assign pix_valid = pv_q;
	assign pix_byte  = pb_q;
	assign hdr_valid = hdv_q;
	assign hdr_vc    = hvc_q;
	assign hdr_dt    = hdt_q;
	assign hdr_wc    = hwc_q;
	assign irq       = irq_q;

	sequence s_stat_rd;
		reg_rd && reg_addr == OFF_STAT;
	endsequence
	sequence s_hdr_end;
		emit_q && hs && ps_q == PS_HDR && pc_q == 16'd3;
	endsequence

	property p_crc_set;
		@(posedge sys_clk) disable iff (!rst_n) crc_ev |=> sts_q[S_CRC] && hdr_valid == 1'b0;
	endproperty
	a_crc_set: assert property (p_crc_set) else $error("line check error not flagged");
	property p_rd_clr;
		@(posedge sys_clk) disable iff (!rst_n) s_stat_rd ##0 !crc_ev |=> !sts_q[S_CRC];
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("status read did not clear");
	property p_crc_off;
		@(posedge sys_clk) disable iff (!rst_n) !ctrl_q[C_CRC] |-> !crc_ev;
	endproperty
	a_crc_off: assert property (p_crc_off) else $error("disabled line check fired");
	property p_burst;
		@(posedge sys_clk) disable iff (!rst_n) !hs |=> lkv == 4'h0;
	endproperty
	a_burst: assert property (p_burst) else $error("lane stayed aligned after burst");
	property p_dsk;
		@(posedge sys_clk) disable iff (!rst_n) dsk_any |=> lkv == 4'h0 && sts_q[S_DSK];
	endproperty
	a_dsk: assert property (p_dsk) else $error("deskew did not realign");
	property p_pass;
		@(posedge sys_clk) disable iff (!rst_n)
			s_hdr_end ##0 !ctrl_q[C_PIX] |=> hdr_valid && hdr_vc == $past(rvc) && hdr_dt == $past(rdt);
	endproperty
	a_pass: assert property (p_pass) else $error("header not passed through");
	property p_remap;
		@(posedge sys_clk) disable iff (!rst_n)
			s_hdr_end ##0 ctrl_q[C_PIX] && vrmp_q[V_EN] && rvc == vrmp_q[3:0]
			|=> hdr_vc == vrmp_q[7:4] && hdr_dt == vrmp_q[13:8];
	endproperty
	a_remap: assert property (p_remap) else $error("pixel remap not applied");
	property p_four;
		@(posedge sys_clk) disable iff (!rst_n) gather && nl == 3'd4 |=> emit_q [*4] ##1 !emit_q;
	endproperty
	a_four: assert property (p_four) else $error("four lane byte count wrong");
	property p_one;
		@(posedge sys_clk) disable iff (!rst_n) gather && nl == 3'd1 |=> emit_q ##1 !emit_q;
	endproperty
	a_one: assert property (p_one) else $error("single lane byte count wrong");
	property p_map;
		@(posedge sys_clk) disable iff (!rst_n)
			ledge && !dsk_any |=> g_lane[0].sh_q[7] == $past(g_lane[0].bt);
	endproperty
	a_map: assert property (p_map) else $error("lane bit not taken from mapped pin");
	property p_irq;
		@(posedge sys_clk) disable iff (!rst_n) irq == |(sts_q & msk_q);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt disagrees with status");
endmodule

// ===== tb/csi_tx_model.sv
`timescale 1ns/1ps
module csi_tx_model
	import csi_rx_pkg::*;
(
	// Link pins
	output logic       lane_clk,
	output logic       lane_hs,
	output logic [3:0] lane_dat
);
	initial begin
		lane_clk = 1'b0;
		lane_hs = 1'b0;
		lane_dat = 4'h5;
	end
	// The clock only runs inside a burst, so every test uses a burst clock.
	task automatic burst(input logic [7:0] b[$], input int n, input logic [7:0] mp,
			input logic [3:0] inv, input bit dsk);
		int nb;
		logic [7:0] by;
		logic [1:0] p;
		logic [3:0] ld;
		nb = b.size() / n + 1;
		lane_hs <= 1'b1;
		for (int t = 0; t < nb * 8; t++) begin
			// Unused lanes toggle so that a lane leak cannot look like data.
			ld = {t[0], ~t[0], t[0], ~t[0]};
			for (int i = 0; i < n; i++) begin
				p = mp[2*i +: 2];
				by = dsk ? DESKEW_BYTE : (t < 8) ? SYNC_BYTE : b[(t/8 - 1)*n + i];
				ld[p] = by[t%8] ^ inv[p];
			end
			// Non-blocking updates keep the pins race-free when a burst starts on a clock edge.
			lane_dat <= ld;
			#40 lane_clk <= 1'b1;
			#40 lane_clk <= 1'b0;
		end
		#40 lane_hs <= 1'b0;
		lane_dat <= ~ld;
		// Blanking after each burst is reckoned from the bench's 80 ns unit interval.
		#(300 + 370 * 80);
	endtask
endmodule

// ===== tb/tb_csi2_input_port_receiver.sv
`timescale 1ns/1ps
module tb_csi2_input_port_receiver;
	import csi_rx_pkg::*;
	logic        sys_clk, rst_n, reg_wr, reg_rd, lane_clk, lane_hs;
	logic        pix_valid, hdr_valid, irq;
	logic [7:0]  reg_addr, pix_byte;
	logic [31:0] reg_wdata, reg_rdata;
	logic [3:0]  lane_dat, hdr_vc;
	logic [5:0]  hdr_dt;
	logic [15:0] hdr_wc;
	logic [7:0]  pq[$];
	int          n_errors, tests_run, nh;

	csi_rx i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.lane_clk(lane_clk), .lane_hs(lane_hs), .lane_dat(lane_dat),
		.pix_valid(pix_valid), .pix_byte(pix_byte), .hdr_valid(hdr_valid),
		.hdr_vc(hdr_vc), .hdr_dt(hdr_dt), .hdr_wc(hdr_wc), .irq(irq));
	csi_tx_model i_tx (.lane_clk(lane_clk), .lane_hs(lane_hs), .lane_dat(lane_dat));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (pix_valid === 1'b1)
			pq.push_back(pix_byte);
		if (hdr_valid === 1'b1)
			nh++;
	end

	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] p[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (p[k])
			for (int j = 0; j < 8; j++)
				c = (c >> 1) ^ (((c[0] ^ p[k][j]) == 1'b1) ? CRC_POLY : 16'h0000);
		return c;
	endfunction
	// Six payload bytes keep every packet a whole number of groups for 1 to 4 lanes.
	task automatic pkt(input logic [3:0] vc, input logic [5:0] dt, input logic [3:0] evc,
			input logic [5:0] edt, input int n, input logic [11:0] mp, input bit bad);
		logic [7:0] b[$];
		logic [7:0] pl[$];
		logic [15:0] c;
		int h0;
		pl = '{8'h11, 8'h22, 8'h33, 8'hC4, 8'h05, 8'hE6};
		c = crc16(pl) ^ {15'h0000, bad};
		b = '{{vc[1:0], dt}, 8'h06, 8'h00, {vc[3:2], 6'h00}};
		b = {b, pl, c[7:0], c[15:8]};
		pq.delete();
		h0 = nh;
		i_tx.burst(b, n, mp[7:0], mp[11:8], 1'b0);
		repeat (10) @(posedge sys_clk);
		chk(32'(pq.size()), 32'h6);
		chk(32'(nh - h0), 32'h1);
		foreach (pl[k]) chk({24'h0, pq[k]}, {24'h0, pl[k]});
		chk({22'h0, hdr_vc, hdr_dt}, {22'h0, evc, edt});
		chk({16'h0, hdr_wc}, 32'h6);
	endtask

	task automatic t_reset();
		rchk(OFF_CTRL, {27'h0, CTRL_RST});
		rchk(OFF_MAP, {20'h0, MAP_RST});
		rchk(OFF_VRMP, 32'h0);
		rchk(OFF_MASK, 32'h0);
		rchk(8'h18, 32'h0);
	endtask
	task automatic t_lanes();
		for (int n = 1; n <= 4; n++) begin
			wr(OFF_CTRL, 32'(8 + n - 1));
			wr(OFF_MAP, 32'h0A1B);
			pkt(4'hA, 6'h2A, 4'hA, 6'h2A, n, 12'hA1B, 1'b0);
			rchk(OFF_STAT, 32'h2);
			rchk(OFF_HDR, {6'h0, 16'h6, 6'h2A, 4'hA});
		end
	endtask
	task automatic t_crc();
		wr(OFF_CTRL, 32'h0B);
		wr(OFF_MAP, 32'h0E4);
		wr(OFF_MASK, 32'h1);
		pkt(4'h1, 6'h2B, 4'h1, 6'h2B, 4, 12'h0E4, 1'b1);
		chk({31'h0, irq}, 32'h1);
		rchk(OFF_STAT, 32'h3);
		@(posedge sys_clk);
		#1 chk({31'h0, irq}, 32'h0);
		rchk(OFF_STAT, 32'h0);
		wr(OFF_CTRL, 32'h03);
		pkt(4'h1, 6'h2B, 4'h1, 6'h2B, 4, 12'h0E4, 1'b1);
		rchk(OFF_STAT, 32'h2);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_remap();
		wr(OFF_VRMP, 32'h7153);
		rchk(OFF_VRMP, 32'h7153);
		wr(OFF_CTRL, 32'h0F);
		pkt(4'h3, 6'h2C, 4'h5, 6'h31, 4, 12'h0E4, 1'b0);
		pkt(4'h2, 6'h2C, 4'h2, 6'h2C, 4, 12'h0E4, 1'b0);
		wr(OFF_CTRL, 32'h0B);
		pkt(4'h3, 6'h2C, 4'h3, 6'h2C, 4, 12'h0E4, 1'b0);
		rchk(OFF_STAT, 32'h2);
	endtask
	task automatic t_deskew();
		logic [7:0] d[$];
		d = '{8'h00, 8'h00, 8'h00, 8'h00};
		i_tx.burst(d, 4, 8'hE4, 4'h0, 1'b1);
		repeat (10) @(posedge sys_clk);
		rchk(OFF_STAT, 32'h4);
	endtask
	// A frame start is a short packet: one header, no payload, no checksum.
	task automatic t_fs();
		logic [7:0] f[$];
		int h0;
		f = '{8'h00, 8'h01, 8'h00, 8'h00};
		wr(OFF_MASK, 32'h8);
		pq.delete();
		h0 = nh;
		i_tx.burst(f, 4, 8'hE4, 4'h0, 1'b0);
		repeat (10) @(posedge sys_clk);
		chk(32'(pq.size()), 32'h0);
		chk(32'(nh - h0), 32'h1);
		chk({6'h0, hdr_wc, hdr_dt, hdr_vc}, {6'h0, 16'h0001, 6'h00, 4'h0});
		chk({31'h0, irq}, 32'h1);
		rchk(OFF_STAT, 32'hA);
	endtask

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_lanes();
		t_crc();
		t_remap();
		t_deskew();
		t_fs();
		summarize();
	end
	// The whole run, blanking gaps included, needs about 365 us.
	initial begin
		#600000;
		n_errors++;
		summarize();
	end
endmodule
